// >>> common/clock_gen_pkg.sv
package clock_gen_pkg;

  // Field widths
  localparam int IDIV_W   = 2;
  localparam int ODIV_W   = 4;
  localparam int MUL_W    = 5;
  localparam int PERIOD_W = 16;
  localparam int ADDR_W   = 2;

  // Register word indices (byte address is four times the index)
  localparam logic [ADDR_W-1:0] CTRL_IDX   = 2'h0;
  localparam logic [ADDR_W-1:0] SYSCFG_IDX = 2'h1;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 2'h2;

  // Control word layout
  localparam int SRC_LSB  = 0;
  localparam int BAND_LSB = 2;
  localparam int IDIV_LSB = 4;
  localparam int ODIV_LSB = 6;
  localparam int MUL_LSB  = 10;

  // System config and status layout
  localparam int HALVE_BIT     = 0;
  localparam int ST_LOCK_BIT   = 0;
  localparam int ST_BAND_BIT   = 1;
  localparam int ST_LOOP_BIT   = 2;
  localparam int ST_PERIOD_LSB = 16;

  // Clock source and band encodings
  typedef enum logic [1:0] {
    SRC_BYPASS_A = 2'b00,
    SRC_BYPASS_B = 2'b01,
    SRC_BYPASS_C = 2'b10,
    SRC_LOOP     = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    BAND_100_150 = 2'b00,
    BAND_150_200 = 2'b01,
    BAND_200_250 = 2'b10,
    BAND_RESERVED = 2'b11
  } vco_band_t;

  // Reset values
  localparam clk_src_t             SRC_RST    = SRC_BYPASS_A;
  localparam vco_band_t            BAND_RST   = BAND_100_150;
  localparam logic [IDIV_W-1:0]    IDIV_RST   = 2'h0;
  localparam logic [ODIV_W-1:0]    ODIV_RST   = 4'h0;
  localparam logic [MUL_W-1:0]     MUL_RST    = 5'h00;
  localparam logic                 HALVE_RST  = 1'b0;
  localparam logic [PERIOD_W-1:0]  PERIOD_RST = 16'h0010;

endpackage

// >>> hdl/tick_divider.sv
`timescale 1ns/100ps
module tick_divider
#(
  parameter int W = 4
)
(
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divisor_in,
  output logic              tick_out
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // Divide the tick stream by divisor plus one
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (tick_in)
    begin
      // Greater-or-equal so a shrinking divisor cannot strand the count
      if (st.count >= divisor_in)
      begin
        next_st.count = '0;
        next_st.tick  = 1'b1;
      end
      else
      begin
        next_st.count = st.count + W'(1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_out = st.tick;

  div_wrap_a: assert property ( // [RULE_03]
    @(posedge clock_in) disable iff (!reset_n_in)
    tick_in && (st.count >= divisor_in) |=> tick_out && (st.count == '0))
    else $error("divider did not emit on wrap");

  div_quiet_a: assert property ( // [RULE_03]
    @(posedge clock_in) disable iff (!reset_n_in)
    !(tick_in && (st.count >= divisor_in)) |=> !tick_out)
    else $error("divider emitted without wrap");

endmodule

// >>> hdl/loop_slew.sv
`timescale 1ns/100ps
module loop_slew
#(
  parameter int W = 16
)
(
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic         ref_tick_in,
  output logic [W-1:0]      period_out,
  output logic              locked_out
);

  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] measured;
    logic [W-1:0] period;
    logic         locked;
  } slew_state_t;

  slew_state_t st;
  slew_state_t next_st;

  // Measure reference period, walk the loop period one step per tick
  always_comb
  begin
    next_st = st;
    if (st.count != '1)
      next_st.count = st.count + W'(1);
    if (ref_tick_in)
    begin
      next_st.count    = W'(1);
      next_st.measured = st.count;
      // Single steps keep the output rate from jumping [RULE_04]
      if (st.period < st.count)
        next_st.period = st.period + W'(1);
      else if (st.period > st.count && st.period > W'(1))
        next_st.period = st.period - W'(1);
    end
    next_st.locked = (next_st.period == next_st.measured);
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st.count    <= '0;
      st.measured <= '0;
      st.period   <= W'(clock_gen_pkg::PERIOD_RST);
      st.locked   <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign period_out = st.period;
  assign locked_out = st.locked;

  slew_step_a: assert property ( // [RULE_04]
    @(posedge clock_in) disable iff (!reset_n_in)
    $changed(st.period) |->
      ((st.period == $past(st.period) + W'(1)) ||
       (st.period == $past(st.period) - W'(1))))
    else $error("loop period jumped by more than one");

endmodule

// >>> hdl/master_clock_pll_config.sv
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// What this block does
// RULE_01: Source select 11 turns the loop on and feeds its output on.
// RULE_02: In loop mode master rate is osc*(mul+1)/((idiv+1)*(odiv+1)).
// RULE_03: The master clock is the VCO output divided by odiv plus one.
// RULE_04: While locking, the master rate moves gradually, never jumps.
// RULE_05: Band 00, 01, 10 pick the three VCO ranges; 11 is reserved. Here band only reads back and flags 11.
// RULE_06: In bypass the master clock is osc/((idiv+1)*(odiv+1)).
// RULE_07: The CPU clock runs at the master rate or at half of it.
// RULE_08: The peripheral system clock runs at the CPU clock rate.
// RULE_09: Software must never write the reserved band encoding.
module master_clock_pll_config
(
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        osc_in,
  input  wire logic [1:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  output logic             master_tick_out,
  output logic             cpu_tick_out,
  output logic             sys_tick_out,
  output logic             locked_out
);

  localparam int PW = clock_gen_pkg::PERIOD_W;

  typedef struct packed {
    logic                              osc_q;
    logic                              osc_prev;
    logic                              osc_edge;
    clock_gen_pkg::clk_src_t           src;
    clock_gen_pkg::vco_band_t          band;
    logic [clock_gen_pkg::IDIV_W-1:0]  idiv;
    logic [clock_gen_pkg::ODIV_W-1:0]  odiv;
    logic [clock_gen_pkg::MUL_W-1:0]   mul;
    logic                              halve;
    logic                              loop_en;
    logic                              band_res;
    logic [PW-1:0]                     acc;
    logic                              vco_tick;
    logic                              waitreq;
    logic [31:0]                       rdata;
  } state_t;

  localparam state_t ST_RESET = '{
    osc_q:    1'b0,
    osc_prev: 1'b0,
    osc_edge: 1'b0,
    src:      clock_gen_pkg::SRC_RST,
    band:     clock_gen_pkg::BAND_RST,
    idiv:     clock_gen_pkg::IDIV_RST,
    odiv:     clock_gen_pkg::ODIV_RST,
    mul:      clock_gen_pkg::MUL_RST,
    halve:    clock_gen_pkg::HALVE_RST,
    loop_en:  1'b0,
    band_res: 1'b0,
    acc:      '0,
    vco_tick: 1'b0,
    waitreq:  1'b1,
    rdata:    32'h0000_0000
  };

  state_t         st;
  state_t         next_st;
  logic           ref_tick;
  logic           master_tick;
  logic           cpu_tick;
  logic [PW-1:0]  loop_period;
  logic           loop_locked;
  logic           dco_wrap;

  // Input divider: oscillator edges down to the reference rate
  tick_divider #(.W(clock_gen_pkg::IDIV_W)) u_in_div
  (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .tick_in    (st.osc_edge),
    .divisor_in (st.idiv),
    .tick_out   (ref_tick)
  );

  // Loop filter: tracks the reference period with slow steps
  loop_slew #(.W(PW)) u_slew
  (
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .ref_tick_in (ref_tick),
    .period_out  (loop_period),
    .locked_out  (loop_locked)
  );

  // Output prescaler after the VCO [RULE_03]
  tick_divider #(.W(clock_gen_pkg::ODIV_W)) u_out_div
  (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .tick_in    (st.vco_tick),
    .divisor_in (st.odiv),
    .tick_out   (master_tick)
  );

  // CPU clock: divide by one or two [RULE_07]
  tick_divider #(.W(1)) u_cpu_div
  (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .tick_in    (master_tick),
    .divisor_in (st.halve),
    .tick_out   (cpu_tick)
  );

  // Main next-state logic
  always_comb
  begin
    logic [PW:0]   sum;
    logic [PW:0]   rem;
    logic [31:0]   rd_value;
    logic [31:0]   old_word;
    logic [31:0]   new_word;
    logic [31:0]   lane_mask;
    sum       = {1'b0, st.acc} + (PW+1)'(st.mul) + (PW+1)'(1);
    rem       = sum - {1'b0, loop_period};
    rd_value  = 32'h0000_0000;
    old_word  = 32'h0000_0000;
    new_word  = 32'h0000_0000;
    lane_mask = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
                 {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
    dco_wrap  = 1'b0;
    next_st   = st;

    // Oscillator edge; pin is taken as synchronous
    next_st.osc_q    = osc_in;
    next_st.osc_prev = st.osc_q;
    next_st.osc_edge = st.osc_q & ~st.osc_prev;

    // Mode decode
    next_st.loop_en  = (st.src == clock_gen_pkg::SRC_LOOP); // [RULE_01]
    // Flagged only; band 11 has no defined VCO range [RULE_05] [RULE_09]
    next_st.band_res = (st.band == clock_gen_pkg::BAND_RESERVED);

    // Digital VCO: (mul+1) steps per clock against the loop period
    next_st.vco_tick = 1'b0;
    if (!st.loop_en)
    begin
      next_st.acc      = '0;
      next_st.vco_tick = ref_tick; // [RULE_06]
    end
    else if (sum >= {1'b0, loop_period})
    begin
      dco_wrap         = 1'b1;
      next_st.vco_tick = 1'b1; // [RULE_02]
      // At most one tick per clock; faster settings saturate here
      if (rem >= {1'b0, loop_period})
        next_st.acc = '0;
      else
        next_st.acc = rem[PW-1:0];
    end
    else
    begin
      next_st.acc = sum[PW-1:0];
    end

    // Control word image, shared by read and merge
    old_word[clock_gen_pkg::SRC_LSB +: 2]  = st.src;
    old_word[clock_gen_pkg::BAND_LSB +: 2] = st.band;
    old_word[clock_gen_pkg::IDIV_LSB +: clock_gen_pkg::IDIV_W] = st.idiv;
    old_word[clock_gen_pkg::ODIV_LSB +: clock_gen_pkg::ODIV_W] = st.odiv;
    old_word[clock_gen_pkg::MUL_LSB +: clock_gen_pkg::MUL_W]   = st.mul;

    // Read mux; unmapped word reads zero
    unique case (address_in)
      clock_gen_pkg::CTRL_IDX:
        rd_value = old_word;
      clock_gen_pkg::SYSCFG_IDX:
        rd_value[clock_gen_pkg::HALVE_BIT] = st.halve;
      clock_gen_pkg::STATUS_IDX:
      begin
        rd_value[clock_gen_pkg::ST_LOCK_BIT] = loop_locked;
        rd_value[clock_gen_pkg::ST_BAND_BIT] = st.band_res;
        rd_value[clock_gen_pkg::ST_LOOP_BIT] = st.loop_en;
        rd_value[clock_gen_pkg::ST_PERIOD_LSB +: PW] = loop_period;
      end
      default:
        rd_value = 32'h0000_0000;
    endcase

    // Avalon slave: one wait state, then complete
    next_st.waitreq = 1'b1;
    if ((read_in || write_in) && st.waitreq)
    begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = rd_value;
    end
    if (write_in && !st.waitreq)
    begin
      new_word = (old_word & ~lane_mask) | (writedata_in & lane_mask);
      unique case (address_in)
        clock_gen_pkg::CTRL_IDX:
        begin
          next_st.src  = clock_gen_pkg::clk_src_t'(
                           new_word[clock_gen_pkg::SRC_LSB +: 2]);
          next_st.band = clock_gen_pkg::vco_band_t'(
                           new_word[clock_gen_pkg::BAND_LSB +: 2]);
          next_st.idiv =
            new_word[clock_gen_pkg::IDIV_LSB +: clock_gen_pkg::IDIV_W];
          next_st.odiv =
            new_word[clock_gen_pkg::ODIV_LSB +: clock_gen_pkg::ODIV_W];
          next_st.mul  =
            new_word[clock_gen_pkg::MUL_LSB +: clock_gen_pkg::MUL_W];
        end
        clock_gen_pkg::SYSCFG_IDX:
          if (byteenable_in[0])
            next_st.halve = writedata_in[clock_gen_pkg::HALVE_BIT];
        default:
          next_st.halve = st.halve;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign readdata_out    = st.rdata;
  assign waitrequest_out = st.waitreq;
  assign master_tick_out = master_tick;
  assign cpu_tick_out    = cpu_tick;
  assign sys_tick_out    = cpu_tick; // Same flop as the CPU tick [RULE_08]
  assign locked_out      = loop_locked;

  // Named sequences: bus transfer steps and a master tick at full CPU rate
  sequence bus_req_s;
    (read_in || write_in) && waitrequest_out;
  endsequence

  sequence bus_done_s;
    !waitrequest_out ##1 waitrequest_out;
  endsequence

  sequence halve_off_tick_s;
    !st.halve && master_tick;
  endsequence

  loop_enable_a: assert property ( // [RULE_01]
    @(posedge clock_in) disable iff (!reset_n_in)
    (st.src == clock_gen_pkg::SRC_LOOP) |=> st.loop_en)
    else $error("loop not enabled for source select 11");

  loop_ratio_a: assert property ( // [RULE_02]
    @(posedge clock_in) disable iff (!reset_n_in)
    st.loop_en |-> (dco_wrap ##1 st.vco_tick) or (!dco_wrap ##1 !st.vco_tick))
    else $error("VCO tick does not follow accumulator wrap");

  band_flag_a: assert property ( // [RULE_05]
    @(posedge clock_in) disable iff (!reset_n_in)
    (st.band == clock_gen_pkg::BAND_RESERVED) ##1
      (st.band == clock_gen_pkg::BAND_RESERVED) |-> st.band_res)
    else $error("reserved band not flagged");

  bypass_path_a: assert property ( // [RULE_06]
    @(posedge clock_in) disable iff (!reset_n_in)
    !st.loop_en |=> (st.vco_tick == $past(ref_tick)) && (st.acc == '0))
    else $error("bypass does not pass the reference tick");

  cpu_full_a: assert property ( // [RULE_07]
    @(posedge clock_in) disable iff (!reset_n_in)
    halve_off_tick_s |=> cpu_tick_out)
    else $error("CPU tick missing at full rate");

  sys_follow_a: assert property ( // [RULE_08]
    @(posedge clock_in) disable iff (!reset_n_in)
    sys_tick_out |-> $past(master_tick_out) && cpu_tick_out)
    else $error("system tick without master tick");

  bus_answer_a: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    bus_req_s |=> bus_done_s)
    else $error("bus answer not after one wait state");

  bus_rdata_a: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    read_in && waitrequest_out && (address_in == 2'h3) |=>
      (readdata_out == 32'h0000_0000))
    else $error("unmapped read not zero");

  master_src_a: assert property ( // [RULE_03]
    @(posedge clock_in) disable iff (!reset_n_in)
    master_tick_out |-> $past(st.vco_tick))
    else $error("master tick without a VCO tick");

  cpu_half_a: assert property ( // [RULE_07]
    @(posedge clock_in) disable iff (!reset_n_in)
    st.halve && cpu_tick_out |=> !cpu_tick_out)
    else $error("CPU tick twice in a row while halved");

endmodule

// >>> verif/osc_source.sv
`timescale 1ns/100ps
// Free running oscillator seen by the block; half period in clocks
module osc_source
(
  input  wire logic       clock_in,
  input  wire logic [7:0] half_in,
  output logic            osc_out
);
  logic [7:0] count;

  // Known start so the first reference period is well formed
  initial
  begin
    count = 8'h00;
    osc_out = 1'b0;
  end

  // Runs free like a crystal; a new half period takes effect at once, compared against the running count
  always @(posedge clock_in)
  begin
    if (count + 8'h01 >= half_in)
    begin
      count <= 8'h00;
      osc_out <= ~osc_out;
    end
    else
      count <= count + 8'h01;
  end
endmodule

// >>> verif/master_clock_pll_config_tb.sv
`timescale 1ns/100ps
module master_clock_pll_config_tb;
  typedef struct {
    logic [1:0] src;
    logic [1:0] band;
    logic [1:0] idiv;
    logic [3:0] odiv;
    logic [4:0] mul;
    logic       halve;
    int         half;
  } row_t;

  logic        clock_in;
  logic        reset_n_in;
  logic        osc_in;
  logic [1:0]  address_in;
  logic        read_in;
  logic        write_in;
  logic [31:0] writedata_in;
  logic [3:0]  byteenable_in;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic        master_tick_out;
  logic        cpu_tick_out;
  logic        sys_tick_out;
  logic        locked_out;
  logic [7:0]  half;
  logic [31:0] rd;
  logic [31:0] ctrl;
  int          err_count;
  int          n_checks;
  int          cycles;
  int          m;
  int          c;
  int          s;
  int          div;
  int          exp_m;
  int          prev;
  int          now;

  // Bands stay within 00..10 here; the reserved code is a hand test
  row_t rows [6] = '{
    '{2'h0, 2'h0, 2'h0, 4'h0, 5'h00, 1'b0, 2},
    '{2'h1, 2'h0, 2'h1, 4'h2, 5'h00, 1'b1, 2},
    '{2'h2, 2'h0, 2'h3, 4'hE, 5'h00, 1'b0, 1},
    '{2'h3, 2'h0, 2'h1, 4'h0, 5'h03, 1'b0, 8},
    '{2'h3, 2'h1, 2'h1, 4'h1, 5'h07, 1'b1, 8},
    '{2'h3, 2'h2, 2'h0, 4'h2, 5'h01, 1'b0, 4}
  };

  master_clock_pll_config u_dut
  (
    .clock_in        (clock_in),
    .reset_n_in      (reset_n_in),
    .osc_in          (osc_in),
    .address_in      (address_in),
    .read_in         (read_in),
    .write_in        (write_in),
    .writedata_in    (writedata_in),
    .byteenable_in   (byteenable_in),
    .readdata_out    (readdata_out),
    .waitrequest_out (waitrequest_out),
    .master_tick_out (master_tick_out),
    .cpu_tick_out    (cpu_tick_out),
    .sys_tick_out    (sys_tick_out),
    .locked_out      (locked_out)
  );

  osc_source u_osc
  (
    .clock_in (clock_in),
    .half_in  (half),
    .osc_out  (osc_in)
  );

  // 25 MHz system clock
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic end_sim();
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Tick counts over a window may differ by one from phase alone
  task automatic chk_near(input int got, input int exp);
    n_checks++;
    if (got > exp + 1 || got < exp - 1)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clock_in);
    address_in <= a;
    writedata_in <= d;
    byteenable_in <= be;
    write_in <= wr;
    read_in <= ~wr;
    // No wait limit here; the hang guard ends a stuck transfer
    do
    begin
      @(posedge clock_in);
    end
    while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  // Counts ticks; sys must match cpu on every cycle
  task automatic count_ticks(input int w, output int mo, output int co,
                             output int so);
    mo = 0;
    co = 0;
    so = 0;
    repeat (w)
    begin
      @(posedge clock_in);
      mo += int'(master_tick_out === 1'b1);
      co += int'(cpu_tick_out === 1'b1);
      so += int'(sys_tick_out === 1'b1);
      chk_val(32'(sys_tick_out), 32'(cpu_tick_out));
    end
  endtask

  // Hang guard well above the expected run length
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_count++;
      $display("[ERR] %0t timeout got %h exp below %h", $time, cycles,
               60000);
      end_sim();
    end
  end

  initial
  begin
    err_count = 0;
    n_checks = 0;
    cycles = 0;
    // Scheduled so the design's reset event cannot be missed at time zero
    reset_n_in <= 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 2'h0;
    writedata_in = 32'h0000_0000;
    byteenable_in = 4'h0;
    half = 8'h02;
    repeat (2) @(posedge clock_in);
    chk_val(readdata_out, 32'h0000_0000);
    chk_val(32'({waitrequest_out, master_tick_out, cpu_tick_out,
                 sys_tick_out, locked_out}), 32'h0000_0010);
    reset_n_in <= 1'b1;
    // Table of modes, dividers and halving
    foreach (rows[i])
    begin
      half <= 8'(rows[i].half);
      ctrl = (32'(rows[i].mul) << clock_gen_pkg::MUL_LSB)
           | (32'(rows[i].odiv) << clock_gen_pkg::ODIV_LSB)
           | (32'(rows[i].idiv) << clock_gen_pkg::IDIV_LSB)
           | (32'(rows[i].band) << clock_gen_pkg::BAND_LSB)
           | 32'(rows[i].src);
      bus(1'b1, clock_gen_pkg::CTRL_IDX, ctrl, 4'hF, rd);
      bus(1'b1, clock_gen_pkg::SYSCFG_IDX, 32'(rows[i].halve), 4'h1, rd);
      bus(1'b0, clock_gen_pkg::CTRL_IDX, 32'h0, 4'hF, rd);
      chk_val(rd, ctrl);
      repeat (2000) @(posedge clock_in);
      bus(1'b0, clock_gen_pkg::STATUS_IDX, 32'h0, 4'hF, rd);
      chk_val(32'(rd[2:1]), 32'(rows[i].src == 2'h3) << 1);
      if (rows[i].src == 2'h3)
        chk_val(32'(locked_out), 32'h0000_0001);
      count_ticks(1200, m, c, s);
      div = 2 * rows[i].half * (int'(rows[i].idiv) + 1)
          * (int'(rows[i].odiv) + 1);
      exp_m = (rows[i].src == 2'h3) ? 1200 * (int'(rows[i].mul) + 1) / div
                                    : 1200 / div;
      chk_near(m, exp_m);
      chk_near(c, exp_m / (int'(rows[i].halve) + 1));
      chk_near(s, exp_m / (int'(rows[i].halve) + 1));
    end
    // Reference slows in loop mode; loop period must creep, not jump
    half <= 8'h0C;
    bus(1'b0, clock_gen_pkg::STATUS_IDX, 32'h0, 4'hF, rd);
    prev = int'(rd[31:16]);
    repeat (300)
    begin
      bus(1'b0, clock_gen_pkg::STATUS_IDX, 32'h0, 4'hF, rd);
      now = int'(rd[31:16]);
      chk_val(32'(now - prev <= 1 && prev - now <= 1), 32'h1);
      prev = now;
    end
    chk_val(32'(rd[31:16]), 32'h0000_0018);
    chk_val(32'(locked_out), 32'h0000_0001);
    // Mid-run reset; everything must fall back to its reset value
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk_val(readdata_out, 32'h0000_0000);
    chk_val(32'({waitrequest_out, master_tick_out, cpu_tick_out,
                 sys_tick_out, locked_out}), 32'h0000_0010);
    reset_n_in <= 1'b1;
    // Status first: the loop period starts moving a few clocks later
    bus(1'b0, clock_gen_pkg::STATUS_IDX, 32'h0, 4'hF, rd);
    chk_val(rd, 32'(clock_gen_pkg::PERIOD_RST) << 16);
    // Reset values, unmapped and read-only places, lane masking
    bus(1'b0, clock_gen_pkg::CTRL_IDX, 32'h0, 4'hF, rd);
    chk_val(rd, 32'h0000_0000);
    bus(1'b1, 2'h3, 32'hFFFF_FFFF, 4'hF, rd);
    bus(1'b0, 2'h3, 32'h0, 4'hF, rd);
    chk_val(rd, 32'h0000_0000);
    bus(1'b1, clock_gen_pkg::STATUS_IDX, 32'hFFFF_FFFF, 4'hF, rd);
    bus(1'b0, clock_gen_pkg::STATUS_IDX, 32'h0, 4'hF, rd);
    chk_val(32'(rd[15:0]), 32'h0000_0000);
    bus(1'b1, clock_gen_pkg::CTRL_IDX, 32'hFFFF_FFFF, 4'h2, rd);
    bus(1'b0, clock_gen_pkg::CTRL_IDX, 32'h0, 4'hF, rd);
    chk_val(rd, 32'h0000_7F00);
    bus(1'b1, clock_gen_pkg::SYSCFG_IDX, 32'h1, 4'hE, rd);
    bus(1'b0, clock_gen_pkg::SYSCFG_IDX, 32'h0, 4'hF, rd);
    chk_val(rd, 32'h0000_0000);
    // Band 11 on purpose, to see the reserved band and loop flags rise
    bus(1'b1, clock_gen_pkg::CTRL_IDX, 32'hFFFF_FFFF, 4'hF, rd);
    bus(1'b0, clock_gen_pkg::CTRL_IDX, 32'h0, 4'hF, rd);
    chk_val(rd, 32'h0000_7FFF);
    bus(1'b0, clock_gen_pkg::STATUS_IDX, 32'h0, 4'hF, rd);
    chk_val(32'(rd[2:1]), 32'h0000_0003);
    end_sim();
  end
endmodule
